// ==== hdl/uwd_pkg.sv ====
// Constants for the upstream window base address decode block
`default_nettype none

package uwd_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int ADDR_W = 12;
  localparam logic [11:0] OFS_WIN1 = 12'h058;
  localparam logic [11:0] OFS_WIN2 = 12'h05c;
  localparam logic [11:0] OFS_WIN3 = 12'h060;
  localparam logic [31:0] BASE_RESET = 32'h00000000;

  // ----------------------------------------------------------------
  // Field layout
  // ----------------------------------------------------------------
  localparam int FLD_SPACE = 0;
  localparam int FLD_PREF = 3;
  localparam int SETUP_EN_BIT = 31;
  localparam int W1_BASE_LSB = 6;
  localparam int W1_MEM_MIN_LSB = 12;
  localparam int W1_IO_MAX_LSB = 8;
  localparam int W2_BASE_LSB = 14;
  localparam int W3_BASE_LSB = 12;
  localparam logic [3:0] RO_FIELD_MASK = 4'hf;
  localparam logic [1:0] TYPE_32 = 2'h0;
  localparam logic [1:0] TYPE_64 = 2'h1;

  // ----------------------------------------------------------------
  // Forwarding control and page table
  // ----------------------------------------------------------------
  localparam int FWD64_EN_BIT = 21;
  localparam int PAGE_CODE_LSB = 16;
  localparam int PAGE_CODE_W = 5;
  localparam logic [4:0] PAGE_CODE_MAX = 5'h11;
  localparam int PAGE_LSB_MIN = 8;
  localparam int LUT_PAGES = 64;
  localparam int LUT_IDX_W = 6;
  localparam int LUT_VALID_BIT = 0;

  // ----------------------------------------------------------------
  // Bus responses
  // ----------------------------------------------------------------
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : uwd_pkg

`default_nettype wire

// ==== hdl/uwd_window_decode.sv ====
// Upstream window base registers with AXI4-Lite access and address decode
//
// Design decision made here: the AXI4-Lite register port.
`timescale 1ns/100ps
`default_nettype none

module uwd_window_decode
  import uwd_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address
  input wire logic awvalid,
  output logic awready,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic [2:0] awprot,
  // AXI4-Lite write data
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  // AXI4-Lite write response
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // AXI4-Lite read address
  input wire logic arvalid,
  output logic arready,
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic [2:0] arprot,
  // AXI4-Lite read data
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // Setup and translation values from the bridge core
  input wire logic [31:0] win1_setup,
  input wire logic [31:0] win1_xlat_base,
  input wire logic [31:0] win3_setup,
  input wire logic [31:0] win3_setup_upper,
  input wire logic [31:0] win3_upper_base,
  input wire logic [31:0] fwd_ctrl,
  // Downstream window 3 range
  input wire logic [63:0] dn3_base,
  input wire logic [63:0] dn3_limit,
  // Page table lookup
  output logic [LUT_IDX_W-1:0] lut_index,
  input wire logic [31:0] lut_entry,
  // Secondary-side decode request
  input wire logic dec_valid,
  input wire logic [63:0] dec_addr,
  input wire logic dec_is_io,
  // Decode result
  output logic dec_done,
  output logic hit_win1,
  output logic hit_win2,
  output logic hit_win3,
  output logic hit_fwd64,
  output logic [63:0] dec_xaddr
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic aw_held;
    logic [ADDR_W-1:0] aw_addr;
    logic w_held;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic b_valid;
    logic [1:0] b_resp;
    logic r_valid;
    logic [31:0] r_data;
    logic [1:0] r_resp;
    logic [31:0] base1;
    logic [31:0] base2;
    logic [31:0] base3;
    logic done;
    logic hit1;
    logic hit2;
    logic hit3;
    logic fwd64;
    logic [63:0] xaddr;
  } uwd_state_s;

  uwd_state_s st;
  uwd_state_s next_st;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Writable base bits of window 1
  function automatic logic [31:0] uwd_w1_mask(input logic [31:0] setup);
    logic [31:0] m;
    m = {setup[31:W1_BASE_LSB], {W1_BASE_LSB{1'b0}}};
    if (setup[FLD_SPACE])
    begin
      // I/O windows never exceed 256B
      m[31:W1_IO_MAX_LSB] = {(32-W1_IO_MAX_LSB){1'b1}};
    end
    else
    begin
      // Memory windows never go below 4KB
      m[W1_MEM_MIN_LSB-1:0] = {W1_MEM_MIN_LSB{1'b0}};
    end
    if (!setup[SETUP_EN_BIT])
    begin
      m = 32'h00000000;
    end
    return m;
  endfunction : uwd_w1_mask

  // Writable base bits of window 3
  function automatic logic [31:0] uwd_w3_mask(input logic [31:0] setup);
    logic [31:0] m;
    m = {setup[31:W3_BASE_LSB], {W3_BASE_LSB{1'b0}}};
    if (!setup[SETUP_EN_BIT])
    begin
      m = 32'h00000000;
    end
    return m;
  endfunction : uwd_w3_mask

  // Byte-lane merge limited to writable bits
  function automatic logic [31:0] uwd_merge(input logic [31:0] old, input logic [31:0] data,
                                             input logic [3:0] strb, input logic [31:0] wmask);
    logic [31:0] lane;
    lane = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
    return (old & ~(lane & wmask)) | (data & lane & wmask);
  endfunction : uwd_merge

  // Register select from a byte address, 0 when unmapped
  function automatic logic [1:0] uwd_reg_sel(input logic [ADDR_W-1:0] addr);
    logic [1:0] sel;
    if (addr[ADDR_W-1:2] == OFS_WIN1[ADDR_W-1:2])
    begin
      sel = 2'h1;
    end
    else if (addr[ADDR_W-1:2] == OFS_WIN2[ADDR_W-1:2])
    begin
      sel = 2'h2;
    end
    else if (addr[ADDR_W-1:2] == OFS_WIN3[ADDR_W-1:2])
    begin
      sel = 2'h3;
    end
    else
    begin
      sel = 2'h0;
    end
    return sel;
  endfunction : uwd_reg_sel

  // ----------------------------------------------------------------
  // Window geometry
  // ----------------------------------------------------------------
  logic [PAGE_CODE_W-1:0] page_code;
  logic [31:0] m1;
  logic [31:0] m2;
  logic [31:0] m3;
  logic [31:0] page_mask;
  logic en64;
  logic [31:0] rd_win1;
  logic [31:0] rd_win2;
  logic [31:0] rd_win3;

  always_comb
  begin
    page_code = fwd_ctrl[PAGE_CODE_LSB +: PAGE_CODE_W];
    // Codes past the largest page clamp so the window stays within 2GB
    if (page_code > PAGE_CODE_MAX)
    begin
      page_code = PAGE_CODE_MAX;
    end
    m1 = uwd_w1_mask(win1_setup);
    // 64 pages of 256B << code: window is 16KB << code
    m2 = 32'hffffffff << (W2_BASE_LSB + int'(page_code));
    page_mask = 32'hffffffff << (PAGE_LSB_MIN + int'(page_code));
    m3 = uwd_w3_mask(win3_setup);
    en64 = fwd_ctrl[FWD64_EN_BIT];
    // Low type bits come straight from setup; stored base is masked
    rd_win1 = (st.base1 & m1) | {28'h0000000, win1_setup[3:0] & RO_FIELD_MASK};
    // Space, width and prefetch of window 2 are fixed at zero
    rd_win2 = st.base2 & m2;
    rd_win3 = (st.base3 & m3) | {28'h0000000, win3_setup[3:0] & RO_FIELD_MASK};
  end

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  logic [31:0] a_lo;
  logic [31:0] a_hi;
  logic d_hit1;
  logic d_hit2;
  logic d_hit3;
  logic d_fwd64;
  logic [31:0] x1;
  logic [31:0] x2;
  logic [31:0] hi_mask;
  logic [31:0] hi_base;
  logic [31:0] page_sel;

  always_comb
  begin
    a_lo = dec_addr[31:0];
    a_hi = dec_addr[63:32];
    page_sel = a_lo >> (PAGE_LSB_MIN + int'(page_code));
    lut_index = page_sel[LUT_IDX_W-1:0];
    d_hit1 = win1_setup[SETUP_EN_BIT] && (dec_is_io == win1_setup[FLD_SPACE]) &&
             (a_hi == 32'h00000000) && (((a_lo ^ st.base1) & m1) == 32'h00000000);
    x1 = (win1_xlat_base & m1) | (a_lo & ~m1);
    d_hit2 = !dec_is_io && (a_hi == 32'h00000000) &&
             (((a_lo ^ st.base2) & m2) == 32'h00000000) &&
             lut_entry[LUT_VALID_BIT];
    x2 = (lut_entry & page_mask) | (a_lo & ~page_mask);
    // Without 64-bit enable the upper half must be zero to hit
    if (en64)
    begin
      hi_mask = win3_setup_upper;
      hi_base = win3_upper_base;
    end
    else
    begin
      hi_mask = 32'hffffffff;
      hi_base = 32'h00000000;
    end
    d_hit3 = win3_setup[SETUP_EN_BIT] && (!en64 || win3_setup_upper[SETUP_EN_BIT]) &&
             !dec_is_io && (((a_hi ^ hi_base) & hi_mask) == 32'h00000000) &&
             (((a_lo ^ st.base3) & m3) == 32'h00000000);
    d_fwd64 = !dec_is_io && (a_hi != 32'h00000000) &&
              ((dec_addr < dn3_base) || (dec_addr > dn3_limit));
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  logic aw_take;
  logic w_take;
  logic ar_take;
  logic [1:0] wr_sel;
  logic [1:0] rd_sel;

  always_comb
  begin
    next_st = st;
    awready = !st.aw_held && !st.b_valid;
    wready = !st.w_held && !st.b_valid;
    arready = !st.r_valid;
    aw_take = awvalid && awready;
    w_take = wvalid && wready;
    ar_take = arvalid && arready;
    wr_sel = uwd_reg_sel(st.aw_addr);
    rd_sel = uwd_reg_sel(araddr);

    if (aw_take)
    begin
      next_st.aw_held = 1'b1;
      next_st.aw_addr = awaddr;
    end
    if (w_take)
    begin
      next_st.w_held = 1'b1;
      next_st.w_data = wdata;
      next_st.w_strb = wstrb;
    end

    // Write commits once both halves are held
    if (st.aw_held && st.w_held)
    begin
      next_st.aw_held = 1'b0;
      next_st.w_held = 1'b0;
      next_st.b_valid = 1'b1;
      next_st.b_resp = RESP_OKAY;
      if (wr_sel == 2'h1)
      begin
        next_st.base1 = uwd_merge(st.base1, st.w_data, st.w_strb, m1);
      end
      else if (wr_sel == 2'h2)
      begin
        next_st.base2 = uwd_merge(st.base2, st.w_data, st.w_strb, m2);
      end
      else if (wr_sel == 2'h3)
      begin
        next_st.base3 = uwd_merge(st.base3, st.w_data, st.w_strb, m3);
      end
      else
      begin
        next_st.b_resp = RESP_SLVERR;
      end
    end
    else if (st.b_valid && bready)
    begin
      next_st.b_valid = 1'b0;
    end

    if (ar_take)
    begin
      next_st.r_valid = 1'b1;
      next_st.r_resp = RESP_OKAY;
      if (rd_sel == 2'h1)
      begin
        next_st.r_data = rd_win1;
      end
      else if (rd_sel == 2'h2)
      begin
        next_st.r_data = rd_win2;
      end
      else if (rd_sel == 2'h3)
      begin
        next_st.r_data = rd_win3;
      end
      else
      begin
        next_st.r_data = 32'h00000000;
        next_st.r_resp = RESP_SLVERR;
      end
    end
    else if (st.r_valid && rready)
    begin
      next_st.r_valid = 1'b0;
    end

    // Decode result is registered one cycle after the request
    next_st.done = dec_valid;
    next_st.hit1 = dec_valid && d_hit1;
    next_st.hit2 = dec_valid && d_hit2;
    next_st.hit3 = dec_valid && d_hit3;
    next_st.fwd64 = dec_valid && d_fwd64;
    if (dec_valid)
    begin
      // Window 1 wins an overlap, then window 2; others pass untouched
      if (d_hit1)
      begin
        next_st.xaddr = {32'h00000000, x1};
      end
      else if (d_hit2)
      begin
        next_st.xaddr = {32'h00000000, x2};
      end
      else
      begin
        next_st.xaddr = dec_addr;
      end
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      st <= '0;
      st.base1 <= BASE_RESET;
      st.base2 <= BASE_RESET;
      st.base3 <= BASE_RESET;
    end
    else
    begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign bvalid = st.b_valid;
  assign bresp = st.b_resp;
  assign rvalid = st.r_valid;
  assign rdata = st.r_data;
  assign rresp = st.r_resp;
  assign dec_done = st.done;
  assign hit_win1 = st.hit1;
  assign hit_win2 = st.hit2;
  assign hit_win3 = st.hit3;
  assign hit_fwd64 = st.fwd64;
  assign dec_xaddr = st.xaddr;

endmodule : uwd_window_decode

`default_nettype wire

// ==== sim/uwd_chk.sv ====
// Assertions on the upstream window block ports
`timescale 1ns/100ps
`default_nettype none
module uwd_chk
  import uwd_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Reads
  input wire logic arvalid,
  input wire logic arready,
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic rvalid,
  input wire logic [31:0] rdata,
  // Setup
  input wire logic [31:0] win1_setup,
  input wire logic [31:0] win3_setup,
  input wire logic [31:0] fwd_ctrl,
  input wire logic [63:0] dn3_base,
  input wire logic [63:0] dn3_limit,
  // Decode
  input wire logic [LUT_IDX_W-1:0] lut_index,
  input wire logic [31:0] lut_entry,
  input wire logic dec_valid,
  input wire logic [63:0] dec_addr,
  input wire logic hit_win1,
  input wire logic hit_win2,
  input wire logic hit_win3,
  input wire logic hit_fwd64,
  input wire logic [63:0] dec_xaddr
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic [ADDR_W-1:0] ra;
  // Offset of the read being answered
  always_ff @(posedge aclk)
  begin
    if (arvalid && arready)
    begin
      ra <= araddr;
    end
  end
  AST_W1_FLD: assert property (
    rvalid && ra == OFS_WIN1 |-> rdata[5:0] == {2'h0, win1_setup[3:0]})
    else $error("w1 low bits");
  AST_W2_LOW: assert property (
    rvalid && ra == OFS_WIN2 |-> rdata[13:0] == 14'h0000) else $error("w2 low bits");
  AST_W2_TYPE: assert property (
    rvalid && ra == OFS_WIN2 |-> rdata[2:0] == {TYPE_32, 1'b0}) else $error("w2 type");
  AST_W3_LOW: assert property (
    rvalid && ra == OFS_WIN3 |-> rdata[11:4] == 8'h00) else $error("w3 low bits");
  AST_W1_DIS: assert property (
    dec_valid && !win1_setup[SETUP_EN_BIT] |=> !hit_win1) else $error("w1 off hit");
  AST_W3_DIS: assert property (
    dec_valid && !win3_setup[SETUP_EN_BIT] |=> !hit_win3) else $error("w3 off hit");
  AST_W2_PG: assert property (
    dec_valid && !lut_entry[LUT_VALID_BIT] |=> !hit_win2) else $error("page off hit");
  AST_IDX: assert property (
    dec_valid && fwd_ctrl[20:16] == 5'h00 |-> lut_index == dec_addr[13:8])
    else $error("page index");
  AST_W3_XL: assert property (
    dec_valid && !fwd_ctrl[FWD64_EN_BIT] ##1 hit_win3 && !hit_win1 && !hit_win2
    |-> dec_xaddr == $past(dec_addr)) else $error("w3 translated");
  AST_FWD: assert property (
    dec_valid && dec_addr[63:32] != 0 && (dec_addr < dn3_base || dec_addr > dn3_limit)
    |=> hit_fwd64) else $error("no forward");
  cover property (hit_win1);
  cover property (hit_win2);
  cover property (hit_win3 && hit_fwd64);
endmodule : uwd_chk
`default_nettype wire

// ==== sim/uwd_lut_model.sv ====
// Page table model answering window 2 lookups
`timescale 1ns/100ps
`default_nettype none
module uwd_lut_model
  import uwd_pkg::*;
(
  // Lookup
  input wire logic [LUT_IDX_W-1:0] lut_index,
  output logic [31:0] lut_entry
);
  // Own page per entry; page 3 left off to catch claims of dead pages
  always_comb
  begin
    lut_entry = {8'h80, 10'h000, lut_index, 7'h00, lut_index != 6'h03};
  end
endmodule : uwd_lut_model
`default_nettype wire

// ==== sim/upstream_bar_window_decode_tb.sv ====
// Register and decode bench for the upstream window block
`timescale 1ns/100ps
`default_nettype none
module upstream_bar_window_decode_tb
  import uwd_pkg::*;
;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, dec_valid, dec_is_io;
  logic awready, wready, bvalid, arready, rvalid, dec_done, hit_win1, hit_win2, hit_win3;
  logic hit_fwd64;
  logic [ADDR_W-1:0] awaddr, araddr;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, resp;
  logic [31:0] wdata, rdata, rd_data, win1_setup, win1_xlat_base, win3_setup, fwd_ctrl;
  logic [31:0] win3_setup_upper, win3_upper_base, lut_entry;
  logic [63:0] dn3_base, dn3_limit, dec_addr, dec_xaddr;
  logic [LUT_IDX_W-1:0] lut_index;
  int errors, num_checks;
  uwd_window_decode dut (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid),
    .awready(awready), .awaddr(awaddr), .awprot(3'h0), .wvalid(wvalid), .wready(wready),
    .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp),
    .arvalid(arvalid), .arready(arready), .araddr(araddr), .arprot(3'h0), .rvalid(rvalid),
    .rready(rready), .rdata(rdata), .rresp(rresp), .win1_setup(win1_setup),
    .win1_xlat_base(win1_xlat_base), .win3_setup(win3_setup),
    .win3_setup_upper(win3_setup_upper), .win3_upper_base(win3_upper_base),
    .fwd_ctrl(fwd_ctrl), .dn3_base(dn3_base), .dn3_limit(dn3_limit), .lut_index(lut_index),
    .lut_entry(lut_entry), .dec_valid(dec_valid), .dec_addr(dec_addr),
    .dec_is_io(dec_is_io), .dec_done(dec_done), .hit_win1(hit_win1), .hit_win2(hit_win2),
    .hit_win3(hit_win3), .hit_fwd64(hit_fwd64), .dec_xaddr(dec_xaddr));
  uwd_lut_model lut (.lut_index(lut_index), .lut_entry(lut_entry));
  initial
  begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end
  task automatic print_verdict();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : print_verdict
  task automatic chk(input string nm, input logic [63:0] s, input logic [63:0] e);
    num_checks++;
    if (s !== e)
    begin
      errors++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic guard(input int n);
    if (n == 50)
    begin
      errors++;
      print_verdict();
    end
  endtask : guard
  // --------------------------------
  // Bus cycles
  // --------------------------------
  // Handshakes sampled mid-cycle, released at the next rising edge
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
    logic ta, tw, tb;
    @(posedge aclk);
    {awvalid, wvalid, bready} <= 3'h7;
    {awaddr, wdata, wstrb} <= {a, d, s};
    tb = 1'b0;
    for (int n = 0; !tb; n++)
    begin
      guard(n);
      @(negedge aclk);
      {ta, tw, tb, resp} = {awready, wready, bvalid, bresp};
      @(posedge aclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      if (tb) bready <= 1'b0;
    end
  endtask : wr
  task automatic rd(input logic [11:0] a);
    logic ta, tr;
    @(posedge aclk);
    {arvalid, rready, araddr} <= {2'h3, a};
    tr = 1'b0;
    for (int n = 0; !tr; n++)
    begin
      guard(n);
      @(negedge aclk);
      {ta, tr, rd_data, resp} = {arready, rvalid, rdata, rresp};
      @(posedge aclk);
      if (ta) arvalid <= 1'b0;
      if (tr) rready <= 1'b0;
    end
  endtask : rd
  task automatic rc(input logic [11:0] a, input logic [31:0] e);
    rd(a);
    chk("rdata", rd_data, e);
  endtask : rc
  task automatic dec(input logic [63:0] a, input logic io, input logic [3:0] h,
    input logic [63:0] x);
    @(posedge aclk);
    {dec_valid, dec_addr, dec_is_io} <= {1'b1, a, io};
    @(posedge aclk);
    dec_valid <= 1'b0;
    @(negedge aclk);
    chk("dec_done", dec_done, 1'b1);
    chk("hits", {hit_win1, hit_win2, hit_win3, hit_fwd64}, h);
    chk("dec_xaddr", dec_xaddr, x);
    // Hand back on a rising edge so the next stimulus change lands there
    @(posedge aclk);
  endtask : dec
  // --------------------------------
  // Sequence
  // --------------------------------
  initial
  begin
    {errors, num_checks} = '0;
    {aresetn, awvalid, wvalid, bready, arvalid, rready, dec_valid, dec_is_io} = '0;
    {awaddr, araddr, wstrb, wdata, win1_setup, win3_setup, fwd_ctrl} = '0;
    {win1_xlat_base, win3_setup_upper, win3_upper_base, dec_addr} = '0;
    {dn3_base, dn3_limit} = {64'h2_0000_0000, 64'h2_ffff_ffff};
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    rc(OFS_WIN1, 32'h0);
    chk("rresp", resp, RESP_OKAY);
    rc(OFS_WIN3, 32'h0);
    wr(OFS_WIN1, 32'hffffffff, 4'hf);
    chk("bresp", resp, RESP_OKAY);
    rc(OFS_WIN1, 32'h0);
    win1_setup <= 32'hffffffc8;
    wr(OFS_WIN1, 32'hffffffff, 4'hf);
    rc(OFS_WIN1, 32'hfffff008);
    win1_setup <= 32'h80000001;
    rc(OFS_WIN1, 32'hfffff001);
    win1_setup <= 32'hfff00008;
    win3_setup <= 32'hfff00002;
    wr(OFS_WIN2, 32'hffffffff, 4'hf);
    rc(OFS_WIN2, 32'hffffc000);
    fwd_ctrl <= 32'h00020000;
    rc(OFS_WIN2, 32'hffff0000);
    fwd_ctrl <= 32'h00110000;
    rc(OFS_WIN2, 32'h80000000);
    fwd_ctrl <= 32'h001f0000;
    rc(OFS_WIN2, 32'h80000000);
    fwd_ctrl <= 32'h0;
    wr(OFS_WIN1, 32'h10000000, 4'hf);
    wr(OFS_WIN2, 32'h40000000, 4'hf);
    wr(OFS_WIN3, 32'h6000ffff, 4'hf);
    wr(OFS_WIN3, 32'hffffffff, 4'h4);
    rc(OFS_WIN1, 32'h10000008);
    rc(OFS_WIN3, 32'h60f00002);
    wr(12'h064, 32'hffffffff, 4'hf);
    chk("bresp", resp, RESP_SLVERR);
    rc(12'h064, 32'h0);
    chk("rresp", resp, RESP_SLVERR);
    win1_xlat_base <= 32'h23400000;
    dec(64'h10012345, 1'b0, 4'h8, 64'h23412345);
    dec(64'h10012345, 1'b1, 4'h0, 64'h10012345);
    dec(64'h40000123, 1'b0, 4'h4, 64'h80000123);
    dec(64'h40003f10, 1'b0, 4'h4, 64'h80003f10);
    dec(64'h40000345, 1'b0, 4'h0, 64'h40000345);
    dec(64'h40004000, 1'b0, 4'h0, 64'h40004000);
    dec(64'h60f12345, 1'b0, 4'h2, 64'h60f12345);
    {win1_setup, win3_setup} <= {32'h7ff00008, 32'h7ff00002};
    dec(64'h10012345, 1'b0, 4'h0, 64'h10012345);
    dec(64'h60f12345, 1'b0, 4'h0, 64'h60f12345);
    win3_setup <= 32'hfff00002;
    {fwd_ctrl, win3_setup_upper, win3_upper_base} <= {32'h00200000, 32'hffffffff, 32'h5};
    dec(64'h5_60f12345, 1'b0, 4'h3, 64'h5_60f12345);
    dec(64'h2_60f12345, 1'b0, 4'h0, 64'h2_60f12345);
    win3_setup_upper <= 32'h7fffffff;
    dec(64'h5_60f12345, 1'b0, 4'h1, 64'h5_60f12345);
    win1_setup <= 32'h80000001;
    dec(64'h100ff0ab, 1'b1, 4'h8, 64'h234000ab);
    print_verdict();
  end
endmodule : upstream_bar_window_decode_tb
bind uwd_window_decode uwd_chk chk (.aclk(aclk), .aresetn(aresetn), .arvalid(arvalid),
  .arready(arready), .araddr(araddr), .rvalid(rvalid), .rdata(rdata),
  .win1_setup(win1_setup), .win3_setup(win3_setup), .fwd_ctrl(fwd_ctrl),
  .dn3_base(dn3_base), .dn3_limit(dn3_limit), .lut_index(lut_index), .lut_entry(lut_entry),
  .dec_valid(dec_valid), .dec_addr(dec_addr), .hit_win1(hit_win1), .hit_win2(hit_win2),
  .hit_win3(hit_win3), .hit_fwd64(hit_fwd64), .dec_xaddr(dec_xaddr));
`default_nettype wire
